/* rtl/pcg_gauge.sv */
// capacity accounting core of the primary cell gauge
module pcg_gauge #(
	parameter int VOLT_LSB_MV = 4,
	parameter int SAMPLE_CYCLES =
		(pcg_pkg::PCG_LOW_WINDOW_MS / pcg_pkg::PCG_LOW_SAMPLES) * 1000
		* pcg_pkg::PCG_CLK_MHZ,
	parameter int RATE_WINDOW_CYCLES = 200000000,
	parameter int SENSE_W = 21
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire pcg_pkg::pcg_straps_t straps,
	input wire logic converterPulse,
	input wire logic signed [SENSE_W-1:0] senseMicrovolts,
	input wire logic [7:0] cellVoltage,
	input wire logic [7:0] temperature,
	input wire logic temperatureValid,
	input wire logic [7:0] efficiencyPercent,
	input wire logic displayButton,
	input wire pcg_pkg::pcg_wr_t regWrite,
	input wire logic [7:0] regReadAddr,
	output logic [7:0] regReadData,
	output pcg_pkg::pcg_level_t efficiencyTable,
	output logic [7:0] efficiencyRate,
	output logic [7:0] efficiencyTemp,
	output logic [4:0] ledSegments,
	output logic configReady
);
	localparam logic [7:0] FIRST_CNT =
		8'(pcg_pkg::PCG_FIRST_MV / VOLT_LSB_MV);
	localparam logic [7:0] FINAL_CNT = 8'((pcg_pkg::PCG_FIRST_MV
		- pcg_pkg::PCG_FINAL_STEP_MV) / VOLT_LSB_MV);
	localparam logic [SENSE_W-1:0] MIN_UV =
		SENSE_W'(pcg_pkg::PCG_SENSE_MIN_UV);
	localparam logic [SENSE_W-1:0] MAX_UV =
		SENSE_W'(pcg_pkg::PCG_SENSE_MAX_UV);
	localparam logic [3:0] LOW_N = 4'(pcg_pkg::PCG_LOW_SAMPLES);

	// full count chosen by the two full-count straps
	function automatic logic [15:0] fullCount(
		input pcg_pkg::pcg_level_t a,
		input pcg_pkg::pcg_level_t b
	);
		logic [15:0] r;
		r = pcg_pkg::PCG_FC_LL;
		case ({a, b})
			{pcg_pkg::PCG_LVL_H, pcg_pkg::PCG_LVL_H}: r = pcg_pkg::PCG_FC_HH;
			{pcg_pkg::PCG_LVL_H, pcg_pkg::PCG_LVL_Z}: r = pcg_pkg::PCG_FC_HZ;
			{pcg_pkg::PCG_LVL_H, pcg_pkg::PCG_LVL_L}: r = pcg_pkg::PCG_FC_HL;
			{pcg_pkg::PCG_LVL_Z, pcg_pkg::PCG_LVL_H}: r = pcg_pkg::PCG_FC_ZH;
			{pcg_pkg::PCG_LVL_Z, pcg_pkg::PCG_LVL_Z}: r = pcg_pkg::PCG_FC_ZZ;
			{pcg_pkg::PCG_LVL_Z, pcg_pkg::PCG_LVL_L}: r = pcg_pkg::PCG_FC_ZL;
			{pcg_pkg::PCG_LVL_L, pcg_pkg::PCG_LVL_H}: r = pcg_pkg::PCG_FC_LH;
			{pcg_pkg::PCG_LVL_L, pcg_pkg::PCG_LVL_Z}: r = pcg_pkg::PCG_FC_LZ;
			default: r = pcg_pkg::PCG_FC_LL;
		endcase
		return r;
	endfunction

	// converter pulses that make one accumulator count
	function automatic logic [3:0] pulsesPerCount(
		input pcg_pkg::pcg_level_t s
	);
		logic [3:0] r;
		case (s)
			pcg_pkg::PCG_LVL_H: r = pcg_pkg::PCG_DIV40;
			pcg_pkg::PCG_LVL_Z: r = pcg_pkg::PCG_DIV80;
			default: r = pcg_pkg::PCG_DIV160;
		endcase
		return r;
	endfunction

	// segment count for the display mode
	function automatic logic [2:0] segCount(
		input pcg_pkg::pcg_level_t s
	);
		logic [2:0] r;
		case (s)
			pcg_pkg::PCG_LVL_H: r = 3'(pcg_pkg::PCG_SEG4);
			pcg_pkg::PCG_LVL_Z: r = 3'(pcg_pkg::PCG_SEG5);
			default: r = 3'(pcg_pkg::PCG_SEG2);
		endcase
		return r;
	endfunction

	logic rstMeta_ff;
	logic rstSync_ff;
	logic rstSyncN;
	pcg_pkg::pcg_state_t state_ff;
	logic [15:0] fullCount_ff;
	logic [3:0] pulseDiv_ff;
	logic [2:0] segMode_ff;
	logic [3:0] pulseCnt_ff;
	logic [15:0] dac_ff;
	logic [7:0] fullRef_ff;
	logic [7:0] volt_ff;
	logic [7:0] temp_ff;
	logic [1:0] emptyFlags_ff;
	logic [3:0] firstRun_ff;
	logic [3:0] finalRun_ff;
	logic [31:0] sampleTimer_ff;
	logic [31:0] rateTimer_ff;
	logic [7:0] rateCnt_ff;
	logic [7:0] rate_ff;
	logic [7:0] peak_ff;
	logic [15:0] cap_ff;
	logic countPulse;
	logic accTick;
	logic sampleTick;
	logic rateTick;
	logic [23:0] nxt_compFull;
	logic [15:0] compFullSat;
	logic [18:0] capScaled;
	logic [15:0] strapFull;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end
	assign rstSyncN = rstSync_ff;

	// start-up sequencing: one strap sample then run
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_ff <= pcg_pkg::PCG_ST_RESET;
		end else begin
			case (state_ff)
				pcg_pkg::PCG_ST_RESET: state_ff <= pcg_pkg::PCG_ST_LATCH;
				pcg_pkg::PCG_ST_LATCH: state_ff <= pcg_pkg::PCG_ST_RUN;
				pcg_pkg::PCG_ST_RUN: state_ff <= pcg_pkg::PCG_ST_RUN;
				default: state_ff <= pcg_pkg::PCG_ST_RESET;
			endcase
		end
	end

	// full count decoded from the live straps, used only while latching
	assign strapFull = fullCount(straps.fullA, straps.fullB);

	// strap latch, taken once after reset release
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			fullCount_ff <= pcg_pkg::PCG_FC_LL;
			pulseDiv_ff <= pcg_pkg::PCG_DIV160;
			segMode_ff <= 3'(pcg_pkg::PCG_SEG2);
			efficiencyTable <= pcg_pkg::PCG_LVL_L;
		end else if (state_ff == pcg_pkg::PCG_ST_LATCH) begin
			fullCount_ff <= strapFull;
			pulseDiv_ff <= pulsesPerCount(straps.scale);
			segMode_ff <= segCount(straps.disp);
			efficiencyTable <= straps.comp;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			configReady <= 1'b0;
		end else begin
			configReady <= state_ff == pcg_pkg::PCG_ST_RUN;
		end
	end

	// magnitude filter: positive and between the two thresholds only
	assign countPulse = converterPulse
		&& (state_ff == pcg_pkg::PCG_ST_RUN)
		&& !senseMicrovolts[SENSE_W-1]
		&& ($unsigned(senseMicrovolts) >= MIN_UV)
		&& ($unsigned(senseMicrovolts) <= MAX_UV);

	// prescale converter pulses to accumulator units
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pulseCnt_ff <= 4'h0;
		end else if (countPulse) begin
			if (pulseCnt_ff + 4'h1 >= pulseDiv_ff) begin
				pulseCnt_ff <= 4'h0;
			end else begin
				pulseCnt_ff <= pulseCnt_ff + 4'h1;
			end
		end
	end
	assign accTick = countPulse && (pulseCnt_ff + 4'h1 >= pulseDiv_ff);

	// discharge accumulator; a host byte write wins over a count
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			dac_ff <= 16'h0000;
		end else if (regWrite.en && regWrite.addr == pcg_pkg::PCG_ADR_DACL) begin
			dac_ff <= {dac_ff[15:8], regWrite.data};
		end else if (regWrite.en && regWrite.addr == pcg_pkg::PCG_ADR_DACH) begin
			dac_ff <= {regWrite.data, dac_ff[7:0]};
		end else if (accTick) begin
			dac_ff <= dac_ff + 16'h0001;
		end
	end

	// full reference: from straps at start, then host only
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			fullRef_ff <= 8'h00;
		end else if (state_ff == pcg_pkg::PCG_ST_LATCH) begin
			if (straps.init == pcg_pkg::PCG_LVL_H) begin
				fullRef_ff <= strapFull[15:8];
			end else begin
				fullRef_ff <= 8'h00;
			end
		end else if (regWrite.en && regWrite.addr == pcg_pkg::PCG_ADR_FREF) begin
			fullRef_ff <= regWrite.data;
		end
	end

	// half-second sample timer for the voltage checks
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sampleTimer_ff <= 32'h0;
		end else if (sampleTimer_ff >= 32'(SAMPLE_CYCLES - 1)) begin
			sampleTimer_ff <= 32'h0;
		end else begin
			sampleTimer_ff <= sampleTimer_ff + 32'h1;
		end
	end
	assign sampleTick = sampleTimer_ff >= 32'(SAMPLE_CYCLES - 1);

	// cell voltage reading
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			volt_ff <= 8'h00;
		end else if (sampleTick) begin
			volt_ff <= cellVoltage;
		end
	end

	// consecutive low sample runs, one per threshold
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			firstRun_ff <= 4'h0;
			finalRun_ff <= 4'h0;
		end else if (sampleTick) begin
			if (cellVoltage < FIRST_CNT) begin
				firstRun_ff <= (firstRun_ff == LOW_N) ? LOW_N : firstRun_ff + 4'h1;
			end else begin
				firstRun_ff <= 4'h0;
			end
			if (cellVoltage < FINAL_CNT) begin
				finalRun_ff <= (finalRun_ff == LOW_N) ? LOW_N : finalRun_ff + 4'h1;
			end else begin
				finalRun_ff <= 4'h0;
			end
		end
	end

	// sticky empty flags
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			emptyFlags_ff <= 2'h0;
		end else begin
			if (firstRun_ff == LOW_N) begin
				emptyFlags_ff[pcg_pkg::PCG_BIT_FIRST] <= 1'b1;
			end
			if (finalRun_ff == LOW_N) begin
				emptyFlags_ff[pcg_pkg::PCG_BIT_FINAL] <= 1'b1;
			end
		end
	end

	// live temperature
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			temp_ff <= 8'h00;
		end else if (temperatureValid) begin
			temp_ff <= temperature;
		end
	end

	// discharge rate: counts per window, saturating
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			rateTimer_ff <= 32'h0;
		end else if (rateTick) begin
			rateTimer_ff <= 32'h0;
		end else begin
			rateTimer_ff <= rateTimer_ff + 32'h1;
		end
	end
	assign rateTick = rateTimer_ff >= 32'(RATE_WINDOW_CYCLES - 1);

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			rateCnt_ff <= 8'h00;
			rate_ff <= 8'h00;
		end else if (rateTick) begin
			rateCnt_ff <= {7'h00, accTick};
			rate_ff <= rateCnt_ff;
		end else if (accTick && rateCnt_ff != 8'hFF) begin
			rateCnt_ff <= rateCnt_ff + 8'h01;
		end
	end

	// peak-held rate for the efficiency lookup
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			peak_ff <= 8'h00;
		end else if (rate_ff > peak_ff) begin
			peak_ff <= rate_ff;
		end
	end

	// lookup operands: held peak, live temperature
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			efficiencyRate <= 8'h00;
			efficiencyTemp <= 8'h00;
		end else begin
			efficiencyRate <= peak_ff;
			efficiencyTemp <= temp_ff;
		end
	end

	// efficiency times reference, in accumulator units
	always_comb begin
		nxt_compFull = 24'((32'(efficiencyPercent) * 32'(fullRef_ff) * 32'h100)
			/ pcg_pkg::PCG_PCT_FULL);
		compFullSat = (nxt_compFull > 24'h00FFFF) ? 16'hFFFF : nxt_compFull[15:0];
	end

	// compensated capacity, floored at zero
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cap_ff <= 16'h0000;
		end else if (compFullSat > dac_ff) begin
			cap_ff <= compFullSat - dac_ff;
		end else begin
			cap_ff <= 16'h0000;
		end
	end

	// segment display against the full count, button gated
	assign capScaled = 19'(cap_ff) * 19'(segMode_ff);
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ledSegments <= 5'h00;
		end else begin
			for (int k = 0; k < 5; k++) begin
				ledSegments[k] <= displayButton
					&& (3'(k) < segMode_ff)
					&& (capScaled > 19'(19'(k) * 19'(fullCount_ff)));
			end
		end
	end

	// register readback
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			regReadData <= 8'h00;
		end else begin
			case (regReadAddr)
				pcg_pkg::PCG_ADR_FLAGS: regReadData <= {6'h00, emptyFlags_ff};
				pcg_pkg::PCG_ADR_TEMP: regReadData <= temp_ff;
				pcg_pkg::PCG_ADR_VOLT: regReadData <= volt_ff;
				pcg_pkg::PCG_ADR_CAPL: regReadData <= cap_ff[7:0];
				pcg_pkg::PCG_ADR_CAPH: regReadData <= cap_ff[15:8];
				pcg_pkg::PCG_ADR_FULL: regReadData <= fullCount_ff[15:8];
				pcg_pkg::PCG_ADR_FREF: regReadData <= fullRef_ff;
				pcg_pkg::PCG_ADR_PEAK: regReadData <= peak_ff;
				pcg_pkg::PCG_ADR_RATE: regReadData <= rate_ff;
				pcg_pkg::PCG_ADR_DACL: regReadData <= dac_ff[7:0];
				pcg_pkg::PCG_ADR_DACH: regReadData <= dac_ff[15:8];
				default: regReadData <= 8'h00;
			endcase
		end
	end
endmodule

/* rtl/pcg_pkg.sv */
// package of constants and types for the primary cell capacity gauge
// Behaviour
// - Count discharge only while the sense potential is positive.
// - Converter pulses are worth 3.125 microvolt-hours each.
// - Sense inputs up to 0.5 V in magnitude are handled.
// - Sense signals below 250 microvolts are filtered out of counting.
// - Cell voltage samples are stored in the reading register at 0Bh.
// - First empty threshold defaults 0.76 V; final sits 0.10 V lower.
// - Eight consecutive low samples over four seconds set that flag at 01h.
// - Empty flags stay set whatever the later voltage does.
// - Temperature is stored at 02h and feeds efficiency compensation.
// - Each counted unit increments the discharge accumulator at 2Eh.
// - Discharge accumulator is 16 bits in full-count units.
// - Compensated capacity equals efficiency times full reference minus accumulator.
// - Peak discharge rate is held, used for efficiency, readable at 12h.
// - Temperature part of efficiency follows live temperature, unlatched.
// - Full reference starts at full count or zero; only host rewrites it.
// - All six straps are sampled once after reset and latched.
// - First two straps pick one of nine full counts, 26112 to 48128.
// - Scale strap picks 1/40, 1/80 or 1/160 mVh per count.
// - Selected full count reads back at 10h.
// - LEDs show capacity against full count while the button is held.
// - High initial-capacity strap copies full count into the reference.
// - Latched compensation strap chooses one of three efficiency tables.
// - Display-mode strap selects two, four or five segments.
package pcg_pkg;
	// three-level strap as seen by the pad receiver
	typedef enum logic [1:0] {
		PCG_LVL_L = 2'h0,
		PCG_LVL_Z = 2'h1,
		PCG_LVL_H = 2'h2
	} pcg_level_t;

	typedef struct packed {
		pcg_level_t fullA;
		pcg_level_t fullB;
		pcg_level_t scale;
		pcg_level_t comp;
		pcg_level_t disp;
		pcg_level_t init;
	} pcg_straps_t;

	// register write request from the serial front end
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} pcg_wr_t;

	typedef enum logic [1:0] {
		PCG_ST_RESET = 2'h0,
		PCG_ST_LATCH = 2'h1,
		PCG_ST_RUN = 2'h3
	} pcg_state_t;

	localparam logic [7:0] PCG_ADR_FLAGS = 8'h01;
	localparam logic [7:0] PCG_ADR_TEMP = 8'h02;
	localparam logic [7:0] PCG_ADR_VOLT = 8'h0B;
	localparam logic [7:0] PCG_ADR_CAPL = 8'h0E;
	localparam logic [7:0] PCG_ADR_CAPH = 8'h0F;
	localparam logic [7:0] PCG_ADR_FULL = 8'h10;
	localparam logic [7:0] PCG_ADR_FREF = 8'h11;
	localparam logic [7:0] PCG_ADR_PEAK = 8'h12;
	localparam logic [7:0] PCG_ADR_RATE = 8'h13;
	localparam logic [7:0] PCG_ADR_DACL = 8'h2E;
	localparam logic [7:0] PCG_ADR_DACH = 8'h2F;

	localparam int PCG_BIT_FINAL = 0;
	localparam int PCG_BIT_FIRST = 1;

	// nine full counts, strap A then strap B
	localparam logic [15:0] PCG_FC_HH = 16'hBC00; // 48128
	localparam logic [15:0] PCG_FC_HZ = 16'hB400; // 46080
	localparam logic [15:0] PCG_FC_HL = 16'hA900; // 43264
	localparam logic [15:0] PCG_FC_ZH = 16'h9C00; // 39936
	localparam logic [15:0] PCG_FC_ZZ = 16'h9600; // 38400
	localparam logic [15:0] PCG_FC_ZL = 16'h8D00; // 36096
	localparam logic [15:0] PCG_FC_LH = 16'h7C00; // 31744
	localparam logic [15:0] PCG_FC_LZ = 16'h7100; // 28928
	localparam logic [15:0] PCG_FC_LL = 16'h6600; // 26112

	// converter resolution in nano-volt-hours and count scales
	localparam int PCG_PULSE_NVH = 3125;
	localparam int PCG_SCALE40_NVH = 25000;
	localparam int PCG_SCALE80_NVH = 12500;
	localparam int PCG_SCALE160_NVH = 6250;
	localparam logic [3:0] PCG_DIV40 = 4'(PCG_SCALE40_NVH / PCG_PULSE_NVH);
	localparam logic [3:0] PCG_DIV80 = 4'(PCG_SCALE80_NVH / PCG_PULSE_NVH);
	localparam logic [3:0] PCG_DIV160 = 4'(PCG_SCALE160_NVH / PCG_PULSE_NVH);

	// sense filter, microvolts
	localparam int PCG_SENSE_MAX_UV = 500000;
	localparam int PCG_SENSE_MIN_UV = 250;

	// empty thresholds in millivolts
	localparam int PCG_FIRST_MV = 760;
	localparam int PCG_FINAL_STEP_MV = 100;
	localparam int PCG_LOW_SAMPLES = 8;
	localparam int PCG_LOW_WINDOW_MS = 4000;

	localparam int PCG_CLK_MHZ = 200;
	localparam int PCG_PCT_FULL = 100;
	localparam int PCG_SEG2 = 2;
	localparam int PCG_SEG4 = 4;
	localparam int PCG_SEG5 = 5;
endpackage

/* tb/pcg_gauge_bench.sv */
// self-checking bench for the capacity gauge
module pcg_gauge_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam pcg_pkg::pcg_straps_t CFG_A = '{fullA: pcg_pkg::PCG_LVL_L,
		fullB: pcg_pkg::PCG_LVL_Z, scale: pcg_pkg::PCG_LVL_Z, comp: pcg_pkg::PCG_LVL_H,
		disp: pcg_pkg::PCG_LVL_Z, init: pcg_pkg::PCG_LVL_H};
	localparam pcg_pkg::pcg_straps_t CFG_B = '{fullA: pcg_pkg::PCG_LVL_H,
		fullB: pcg_pkg::PCG_LVL_H, scale: pcg_pkg::PCG_LVL_L, comp: pcg_pkg::PCG_LVL_L,
		disp: pcg_pkg::PCG_LVL_L, init: pcg_pkg::PCG_LVL_L};
	localparam pcg_pkg::pcg_straps_t CFG_C = '{fullA: pcg_pkg::PCG_LVL_Z,
		fullB: pcg_pkg::PCG_LVL_L, scale: pcg_pkg::PCG_LVL_H, comp: pcg_pkg::PCG_LVL_Z,
		disp: pcg_pkg::PCG_LVL_H, init: pcg_pkg::PCG_LVL_H};
	localparam logic [15:0] FULL_A = pcg_pkg::PCG_FC_LZ;
	localparam logic signed [20:0] GOOD = 21'sh3E8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pcg_pkg::pcg_straps_t straps;
	logic converterPulse = 1'b0;
	logic signed [20:0] senseMicrovolts = 21'sh0;
	logic [7:0] cellVoltage = 8'hC8;
	logic [7:0] temperature = 8'h14;
	logic temperatureValid = 1'b0;
	logic [7:0] efficiencyPercent = 8'h64;
	logic displayButton = 1'b0;
	pcg_pkg::pcg_wr_t regWrite;
	logic [7:0] regReadAddr;
	logic [7:0] regReadData;
	pcg_pkg::pcg_level_t efficiencyTable;
	logic [7:0] efficiencyRate;
	logic [7:0] efficiencyTemp;
	logic [4:0] ledSegments;
	logic configReady;
	int n_mismatch = 0;
	int checks = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	pcg_gauge #(.SAMPLE_CYCLES(8), .RATE_WINDOW_CYCLES(16)) uut (.clk(clk), .rst_n(rst_n),
		.straps(straps), .converterPulse(converterPulse), .senseMicrovolts(senseMicrovolts),
		.cellVoltage(cellVoltage), .temperature(temperature),
		.temperatureValid(temperatureValid), .efficiencyPercent(efficiencyPercent),
		.displayButton(displayButton), .regWrite(regWrite), .regReadAddr(regReadAddr),
		.regReadData(regReadData), .efficiencyTable(efficiencyTable),
		.efficiencyRate(efficiencyRate), .efficiencyTemp(efficiencyTemp),
		.ledSegments(ledSegments), .configReady(configReady));
	pcg_host_model host (.clk(clk), .regWrite(regWrite), .regReadAddr(regReadAddr),
		.regReadData(regReadData));

	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	// 16-bit value read as low then high byte
	task automatic rc16(input logic [7:0] a, input logic [15:0] exp);
		rc(a, exp[7:0]);
		rc(a + 8'h01, exp[15:8]);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulses(input int n, input logic signed [20:0] s);
		repeat (n) begin
			@(negedge clk);
			converterPulse = 1'b1;
			senseMicrovolts = s;
			@(negedge clk);
			converterPulse = 1'b0;
		end
	endtask
	task automatic do_reset(input pcg_pkg::pcg_straps_t s);
		int i;
		@(negedge clk);
		rst_n = 1'b0;
		straps = s;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		for (i = 0; i < 20 && configReady !== 1'b1; i++) @(negedge clk);
		if (configReady === 1'b1) begin
			$display("reset done");
		end else begin
			n_mismatch++;
			summarize();
		end
	endtask

	task automatic t_config_a();
		rc(pcg_pkg::PCG_ADR_FULL, FULL_A[15:8]);
		rc(pcg_pkg::PCG_ADR_FREF, FULL_A[15:8]);
		chk(16'(efficiencyTable), 16'(pcg_pkg::PCG_LVL_H));
		$display("config A done");
	endtask
	// refused pulses between accepted ones must not clear the prescaler
	task automatic t_count();
		pulses(3, GOOD);
		pulses(1, 21'sh64);
		pulses(1, -21'sh5);
		pulses(1, 21'sh927C0);
		pulses(1, GOOD);
		cyc(3);
		rc16(pcg_pkg::PCG_ADR_DACL, 16'h0001);
		$display("counting done");
	endtask
	task automatic t_capacity();
		rc16(pcg_pkg::PCG_ADR_CAPL, FULL_A - 16'h0001);
		efficiencyPercent = 8'h32;
		cyc(2);
		rc16(pcg_pkg::PCG_ADR_CAPL, (FULL_A >> 1) - 16'h0001);
		efficiencyPercent = 8'h64;
		host.wr(pcg_pkg::PCG_ADR_FREF, 8'h80);
		rc(pcg_pkg::PCG_ADR_FREF, 8'h80);
		rc16(pcg_pkg::PCG_ADR_CAPL, 16'h7FFF);
		host.wr(pcg_pkg::PCG_ADR_FULL, 8'h00);
		rc(pcg_pkg::PCG_ADR_FULL, FULL_A[15:8]);
		host.wr(pcg_pkg::PCG_ADR_DACL, 8'hFF);
		host.wr(pcg_pkg::PCG_ADR_DACH, 8'hFF);
		rc16(pcg_pkg::PCG_ADR_DACL, 16'hFFFF);
		rc16(pcg_pkg::PCG_ADR_CAPL, 16'h0000);
		$display("capacity done");
	endtask
	task automatic t_display();
		displayButton = 1'b1;
		cyc(2);
		chk({11'h000, ledSegments}, 16'h0000);
		host.wr(pcg_pkg::PCG_ADR_DACL, 8'h00);
		host.wr(pcg_pkg::PCG_ADR_DACH, 8'h00);
		cyc(2);
		chk({11'h000, ledSegments}, 16'h001F);
		displayButton = 1'b0;
		cyc(2);
		chk({11'h000, ledSegments}, 16'h0000);
		$display("display done");
	endtask
	// pulses every other cycle give two counts per 16-cycle window
	task automatic t_peak();
		pulses(64, GOOD);
		cyc(40);
		rc(pcg_pkg::PCG_ADR_RATE, 8'h00);
		rc(pcg_pkg::PCG_ADR_PEAK, 8'h02);
		chk({8'h00, efficiencyRate}, 16'h0002);
		rc16(pcg_pkg::PCG_ADR_DACL, 16'h0010);
		$display("peak rate done");
	endtask
	task automatic t_temp();
		logic [7:0] v[2] = '{8'h3C, 8'h0A};
		foreach (v[i]) begin
			@(negedge clk);
			temperature = v[i];
			temperatureValid = 1'b1;
			@(negedge clk);
			temperatureValid = 1'b0;
			cyc(3);
			rc(pcg_pkg::PCG_ADR_TEMP, v[i]);
			chk({8'h00, efficiencyTemp}, {8'h00, v[i]});
		end
		$display("temperature done");
	endtask
	// thresholds are codes 190 and 165 at 4 mV per step
	task automatic t_flags();
		rc(pcg_pkg::PCG_ADR_VOLT, 8'hC8);
		cellVoltage = 8'hB4;
		cyc(52);
		cellVoltage = 8'hC8;
		cyc(20);
		rc(pcg_pkg::PCG_ADR_FLAGS, 8'h00);
		cellVoltage = 8'hB4;
		cyc(100);
		rc(pcg_pkg::PCG_ADR_FLAGS, 8'h02);
		rc(pcg_pkg::PCG_ADR_VOLT, 8'hB4);
		cellVoltage = 8'hC8;
		cyc(100);
		rc(pcg_pkg::PCG_ADR_FLAGS, 8'h02);
		cellVoltage = 8'hA0;
		cyc(100);
		rc(pcg_pkg::PCG_ADR_FLAGS, 8'h03);
		$display("empty flags done");
	endtask
	task automatic t_config_b();
		do_reset(CFG_B);
		rc(pcg_pkg::PCG_ADR_FULL, pcg_pkg::PCG_FC_HH[15:8]);
		rc(pcg_pkg::PCG_ADR_FREF, 8'h00);
		rc(pcg_pkg::PCG_ADR_FLAGS, 8'h00);
		chk(16'(efficiencyTable), 16'(pcg_pkg::PCG_LVL_L));
		pulses(2, GOOD);
		cyc(3);
		rc16(pcg_pkg::PCG_ADR_DACL, 16'h0001);
		host.wr(pcg_pkg::PCG_ADR_FREF, pcg_pkg::PCG_FC_HH[15:8]);
		displayButton = 1'b1;
		cyc(2);
		chk({11'h000, ledSegments}, 16'h0003);
		displayButton = 1'b0;
		$display("config B done");
	endtask
	// scale H, comp Z and four-segment display after a further reset
	task automatic t_config_c();
		do_reset(CFG_C);
		rc(pcg_pkg::PCG_ADR_FULL, pcg_pkg::PCG_FC_ZL[15:8]);
		rc(pcg_pkg::PCG_ADR_FREF, pcg_pkg::PCG_FC_ZL[15:8]);
		chk(16'(efficiencyTable), 16'(pcg_pkg::PCG_LVL_Z));
		pulses(8, GOOD);
		cyc(3);
		rc16(pcg_pkg::PCG_ADR_DACL, 16'h0001);
		displayButton = 1'b1;
		cyc(2);
		chk({11'h000, ledSegments}, 16'h000F);
		displayButton = 1'b0;
		$display("config C done");
	endtask

	// main sequence
	initial begin
		straps = CFG_A;
		do_reset(CFG_A);
		t_config_a();
		t_count();
		t_capacity();
		t_display();
		t_peak();
		t_temp();
		t_flags();
		t_config_b();
		t_config_c();
		summarize();
	end
endmodule

bind pcg_gauge pcg_gauge_monitor mon (.clk(clk), .rst_n(rst_n), .straps(straps),
	.temperature(temperature), .temperatureValid(temperatureValid),
	.displayButton(displayButton), .regReadAddr(regReadAddr), .regReadData(regReadData),
	.efficiencyTable(efficiencyTable), .efficiencyRate(efficiencyRate),
	.efficiencyTemp(efficiencyTemp), .ledSegments(ledSegments), .configReady(configReady));

/* tb/pcg_gauge_monitor.sv */
// assertion checker watching the capacity gauge ports
module pcg_gauge_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire pcg_pkg::pcg_straps_t straps,
	input wire logic [7:0] temperature,
	input wire logic temperatureValid,
	input wire logic displayButton,
	input wire logic [7:0] regReadAddr,
	input wire logic [7:0] regReadData,
	input wire pcg_pkg::pcg_level_t efficiencyTable,
	input wire logic [7:0] efficiencyRate,
	input wire logic [7:0] efficiencyTemp,
	input wire logic [4:0] ledSegments,
	input wire logic configReady
);
	// one clock domain, reset disables all checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// straps latched within a few edges of release, then held
	a_ready_after_release: assert property ($rose(rst_n) |-> ##[1:8] configReady)
		else $error("config not latched after reset release");
	a_ready_stays_high: assert property (configReady |=> configReady)
		else $error("config ready dropped");
	a_table_from_strap: assert property (configReady |-> efficiencyTable == straps.comp)
		else $error("table select differs from strap");
	a_table_held_stable: assert property ($past(configReady) |-> $stable(efficiencyTable))
		else $error("table select changed in run");
	// display lit only while the button is pressed, at most two segments in two-segment mode
	a_leds_need_button: assert property (!$past(displayButton) |-> ledSegments == 5'h00)
		else $error("segments lit without button");
	a_two_segment_mode: assert property (configReady && straps.disp == pcg_pkg::PCG_LVL_L
		|-> ledSegments[4:2] == 3'h0)
		else $error("segment outside two-segment mode");
	// temperature factor follows the live reading; peak rate and empty flags never drop
	a_temp_follows: assert property (configReady && temperatureValid
		|-> ##2 efficiencyTemp == $past(temperature, 2))
		else $error("temperature factor not following");
	a_peak_never_drops: assert property ($past(configReady)
		|-> efficiencyRate >= $past(efficiencyRate))
		else $error("peak rate decreased");
	a_empty_flags_stick: assert property ($past(regReadAddr) == pcg_pkg::PCG_ADR_FLAGS
		&& $past(regReadAddr, 2) == pcg_pkg::PCG_ADR_FLAGS
		|-> (regReadData[1:0] & $past(regReadData[1:0])) == $past(regReadData[1:0]))
		else $error("empty flag cleared");

	// main scenarios reached
	c_ready: cover property ($rose(configReady));
	c_all_lit: cover property (ledSegments == 5'h1F);
	c_peak: cover property (efficiencyRate == 8'h02);
	c_four_lit: cover property (ledSegments == 5'h0F);
	c_two_lit: cover property (ledSegments == 5'h03);
endmodule

/* tb/pcg_host_model.sv */
// host side of the register link: writes and reads gauge registers
module pcg_host_model (
	input wire logic clk,
	output pcg_pkg::pcg_wr_t regWrite,
	output logic [7:0] regReadAddr,
	input wire logic [7:0] regReadData
);
	// idle link at time zero
	initial begin
		regWrite = '0;
		regReadAddr = 8'h00;
	end
	// one-cycle write, then the released fields show inverted junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrite = '{en: 1'b1, addr: a, data: d};
		@(negedge clk);
		regWrite = '{en: 1'b0, addr: ~a, data: ~d};
		@(negedge clk);
	endtask
	// address held, data taken one cycle after it is sampled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		regReadAddr = a;
		@(negedge clk);
		@(negedge clk);
		d = regReadData;
	endtask
endmodule
